// ---- rtl/ips_defs.svh ----
`ifndef IPS_DEFS_SVH
`define IPS_DEFS_SVH

// Register offsets inside the special-function page.
`define IPS_OFS_IE1      4'h0
`define IPS_OFS_IE2      4'h1
`define IPS_OFS_IFG1     4'h2
`define IPS_OFS_IFG2     4'h3
`define IPS_OFS_ME1      4'h4
`define IPS_OFS_ME2      4'h5
`define IPS_SFR_BYTES    6
`define IPS_SFR_PAGE     12'h000

// Implemented bits and reset image, byte n of the image is offset n.
`define IPS_SFR_MASK     48'h0300_831f_870f
`define IPS_SFR_RST      48'h0000_0202_0000

// Bit positions in the 48-bit image.
`define IPS_B_WDT_EN     0
`define IPS_B_OF_EN      1
`define IPS_B_P00IE      2
`define IPS_B_P01IE      3
`define IPS_B_RXIE       8
`define IPS_B_TXIE       9
`define IPS_B_TP_EN      10
`define IPS_B_BT_EN      15
`define IPS_B_WDT        16
`define IPS_B_OF         17
`define IPS_B_P00        18
`define IPS_B_P01        19
`define IPS_B_NMI        20
`define IPS_B_RX         24
`define IPS_B_TX         25
`define IPS_B_BT         31
`define IPS_B_RXE        40
`define IPS_B_TXE        41

// Vector table base and request priorities.
`define IPS_VEC_BASE     16'hffe0
`define IPS_P_RESET      4'hf
`define IPS_P_NMI        4'he
`define IPS_P_P00        4'hd
`define IPS_P_P01        4'hc
`define IPS_P_WDT        4'ha
`define IPS_P_TA0        4'h9
`define IPS_P_TA         4'h8
`define IPS_P_RX         4'h7
`define IPS_P_TX         4'h6
`define IPS_P_TP         4'h4
`define IPS_P_P2         4'h3
`define IPS_P_P1         4'h2
`define IPS_P_BT         4'h1
`define IPS_P_P0U        4'h0

`endif

// ---- rtl/ips_enc_if.sv ----
`default_nettype none
interface ips_enc_if;
   import ips_pkg::*;
   ips_req_t  req;
   logic      valid;
   ips_prio_t idx;
   modport enc (input req, output valid, output idx);
   modport ctl (output req, input valid, input idx);
endinterface
`default_nettype wire

// ---- rtl/ips_pkg.sv ----
`default_nettype none
package ips_pkg;
   typedef logic [15:0] ips_addr_t;
   typedef logic [7:0]  ips_byte_t;
   typedef logic [3:0]  ips_prio_t;
   typedef logic [15:0] ips_req_t;
endpackage
`default_nettype wire

// ---- rtl/ips_prio_enc.sv ----
`default_nettype none
module ips_prio_enc (
   ips_enc_if.enc e
);
   import ips_pkg::*;

   // Later loop passes overwrite earlier ones, so the top set bit wins.
   always_comb begin
      e.valid = |e.req;
      e.idx   = '0;
      for (int i = 0; i < 16; i++) begin
         if (e.req[i]) begin
            e.idx = 4'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ips_sfr_bit.sv ----
`default_nettype none
module ips_sfr_bit #(
   parameter logic RST = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   input  wire logic wr,
   input  wire logic wdat,
   output var  logic q
);
   logic q_q;
   logic q_d;

   // A hardware set outranks a software write or an acknowledge clear.
   always_comb begin
      q_d = q_q;
      if (set) begin
         q_d = 1'b1;
      end else if (wr) begin
         q_d = wdat;
      end else if (clr) begin
         q_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_q <= RST;
      end else begin
         q_q <= q_d;
      end
   end

   assign q = q_q;

   property p_set_wins;
      @(posedge clk) disable iff (rst) set |=> q_q;
   endproperty
   a_set_wins:
      assert property (p_set_wins) else $error("Set was lost.");
endmodule
`default_nettype wire

// ---- rtl/ips_sfr_irq.sv ----
`include "ips_defs.svh"
`default_nettype none
// Notes on behaviour
// - Any reset source requests vector FFFEh, priority 15.
// - Pin NMI and oscillator fault share FFFCh.
// - Pin NMI ignores every enable bit.
// - Oscillator fault obeys its enable, not global.
// - Port-0 bit 1 request: priority 12, FFF8h.
// - Port-0 bits 2-7 share priority 0, FFE0h.
// - Any port-2 flag requests priority 3, FFE6h.
// - Any port-1 flag requests priority 2, FFE4h.
// - Timer A and timer-port flags stay in their modules; lines only.
// - Enable and flag bits live at 0000h-000Fh.
// - Unassigned special-function bits hold no storage.
// - Watchdog flag set on overflow or key violation.
// - Watchdog flag cleared by power-on or pin reset.
// - Oscillator fault flag sets on fault, resets to one.
// - Pin NMI event sets the NMI flag.
// - 03h: receive, transmit (reset one), basic timer.
// - 05h bit 0: receive or SPI enable.
// - 05h bit 1: transmit enable, none in SPI.
// - Read/write zero-reset bits cleared by power-up clear.
// - Individual enables for port-0 bits 0-1, watchdog, oscillator fault, receive, transmit, timer-port, basic timer only.
// - Vectors fill top sixteen words, handler addresses.
// - Any taken request wakes the core.
module ips_sfr_irq (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              por_event,
   input  wire logic              rst_pin_reset,
   input  wire logic              nmi_pin,
   input  wire logic              wdt_overflow,
   input  wire logic              wdt_key_violation,
   input  wire logic              wdt_interval_mode,
   input  wire logic              osc_fault_det,
   input  wire logic              port0_bit0_set,
   input  wire logic              port0_bit1_set,
   input  wire logic              serial_rx_set,
   input  wire logic              serial_tx_set,
   input  wire logic              basic_timer_set,
   input  wire logic [5:0]        port0_upper_flags,
   input  wire logic [7:0]        port1_flags,
   input  wire logic [7:0]        port2_flags,
   input  wire logic              timer_port_req,
   input  wire logic              timer_a_cc0_req,
   input  wire logic              timer_a_req,
   input  wire logic              sync_mode,
   input  wire logic              global_irq_enable,
   input  wire ips_pkg::ips_addr_t sfr_addr,
   input  wire logic              sfr_rd,
   input  wire logic              sfr_wr,
   input  wire ips_pkg::ips_byte_t sfr_wdata,
   output var  ips_pkg::ips_byte_t sfr_rdata,
   output var  logic              irq_req,
   output var  ips_pkg::ips_addr_t irq_vec_addr,
   input  wire logic              irq_ack,
   output var  logic              cpu_wake,
   output var  logic              system_reset_req,
   output var  logic              serial_rx_module_enable,
   output var  logic              serial_tx_module_enable,
   output var  logic              sync_serial_module_enable
);
   import ips_pkg::*;

   localparam logic [47:0] SFR_MASK = `IPS_SFR_MASK;
   localparam logic [47:0] SFR_RST  = `IPS_SFR_RST;

   function automatic ips_addr_t vec_of(input ips_prio_t p);
      vec_of = `IPS_VEC_BASE | {11'h000, p, 1'b0};
   endfunction

   // Reset-pin NMI synchroniser and edge detector.
   logic nmi_s1_q;
   logic nmi_s2_q;
   logic nmi_s3_q;
   logic nmi_lvl_q;
   logic nmi_lvl_d;
   logic nmi_edge;

   // The level only moves once the last two stages agree.
   always_comb begin
      nmi_lvl_d = nmi_lvl_q;
      if (nmi_s2_q == nmi_s3_q) begin
         nmi_lvl_d = nmi_s3_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nmi_s1_q  <= 1'b0;
         nmi_s2_q  <= 1'b0;
         nmi_s3_q  <= 1'b0;
         nmi_lvl_q <= 1'b0;
      end else begin
         nmi_s1_q  <= nmi_pin;
         nmi_s2_q  <= nmi_s1_q;
         nmi_s3_q  <= nmi_s2_q;
         nmi_lvl_q <= nmi_lvl_d;
      end
   end

   assign nmi_edge = nmi_lvl_d & ~nmi_lvl_q;

   // Register bus decode for the special-function page.
   logic       sfr_hit;
   logic [3:0] sfr_ofs;
   logic [5:0] byte_wr;

   assign sfr_hit = sfr_addr[15:4] == `IPS_SFR_PAGE;
   assign sfr_ofs = sfr_addr[3:0];

   always_comb begin
      for (int k = 0; k < `IPS_SFR_BYTES; k++) begin
         byte_wr[k] = sfr_wr && sfr_hit && sfr_ofs == 4'(k);
      end
   end

   // Per-bit set, clear and reset terms of the register image.
   logic [47:0] img;
   logic [47:0] set_v;
   logic [47:0] clr_v;
   logic [47:0] rst_v;
   logic        ack_p;
   ips_prio_t   prio_q;

   always_comb begin
      set_v = '0;
      set_v[`IPS_B_WDT] = wdt_overflow | wdt_key_violation;
      set_v[`IPS_B_OF]  = osc_fault_det;
      set_v[`IPS_B_P00] = port0_bit0_set;
      set_v[`IPS_B_P01] = port0_bit1_set;
      set_v[`IPS_B_NMI] = nmi_edge;
      set_v[`IPS_B_RX]  = serial_rx_set;
      set_v[`IPS_B_TX]  = serial_tx_set;
      set_v[`IPS_B_BT]  = basic_timer_set;
   end

   // Single-source flags clear when their vector is taken. Shared
   // sources are left to the handler, which must find the cause.
   always_comb begin
      clr_v = '0;
      clr_v[`IPS_B_P00] = ack_p && prio_q == `IPS_P_P00;
      clr_v[`IPS_B_P01] = ack_p && prio_q == `IPS_P_P01;
      clr_v[`IPS_B_WDT] = ack_p && prio_q == `IPS_P_WDT;
      clr_v[`IPS_B_RX]  = ack_p && prio_q == `IPS_P_RX;
      clr_v[`IPS_B_TX]  = ack_p && prio_q == `IPS_P_TX;
      clr_v[`IPS_B_BT]  = ack_p && prio_q == `IPS_P_BT;
   end

   // The watchdog flag survives a watchdog-caused clear so that
   // software can tell the reset causes apart.
   always_comb begin
      rst_v = {48{sys_rst}};
      rst_v[`IPS_B_WDT] = sys_rst & (por_event | rst_pin_reset);
   end

   genvar gi;
   generate
      for (gi = 0; gi < 48; gi++) begin : g_bit
         if (SFR_MASK[gi]) begin : g_on
            ips_sfr_bit #(
               .RST (SFR_RST[gi])
            ) u_bit (
               .clk  (clk),
               .rst  (rst_v[gi]),
               .set  (set_v[gi]),
               .clr  (clr_v[gi]),
               .wr   (byte_wr[gi / 8]),
               .wdat (sfr_wdata[gi % 8]),
               .q    (img[gi])
            );
         end else begin : g_off
            assign img[gi] = 1'b0;
         end
      end
   endgenerate

   // Registered read data; everything outside the map reads zero.
   ips_byte_t rdata_q;
   ips_byte_t rdata_d;

   always_comb begin
      rdata_d = '0;
      if (sfr_rd && sfr_hit && sfr_ofs < 4'(`IPS_SFR_BYTES)) begin
         rdata_d = img[8 * sfr_ofs +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;

   // Request vector, one bit per priority level.
   ips_enc_if enc ();
   logic glb_en;

   assign glb_en = global_irq_enable;

   logic rst_pend_q;

   always_comb begin
      enc.req = '0;
      enc.req[`IPS_P_RESET] = rst_pend_q;
      enc.req[`IPS_P_NMI]   = img[`IPS_B_NMI]
                            | (img[`IPS_B_OF] & img[`IPS_B_OF_EN]);
      enc.req[`IPS_P_P00]   = img[`IPS_B_P00] & img[`IPS_B_P00IE] & glb_en;
      enc.req[`IPS_P_P01]   = img[`IPS_B_P01] & img[`IPS_B_P01IE]
                            & glb_en;
      enc.req[`IPS_P_WDT]   = img[`IPS_B_WDT] & img[`IPS_B_WDT_EN]
                            & wdt_interval_mode & glb_en;
      enc.req[`IPS_P_TA0]   = timer_a_cc0_req & glb_en;
      enc.req[`IPS_P_TA]    = timer_a_req & glb_en;
      enc.req[`IPS_P_RX]    = img[`IPS_B_RX] & img[`IPS_B_RXIE] & glb_en;
      enc.req[`IPS_P_TX]    = img[`IPS_B_TX] & img[`IPS_B_TXIE] & glb_en;
      enc.req[`IPS_P_TP]    = timer_port_req & img[`IPS_B_TP_EN] & glb_en;
      enc.req[`IPS_P_P2]    = (|port2_flags) & glb_en;
      enc.req[`IPS_P_P1]    = (|port1_flags) & glb_en;
      enc.req[`IPS_P_BT]    = img[`IPS_B_BT] & img[`IPS_B_BT_EN] & glb_en;
      enc.req[`IPS_P_P0U]   = (|port0_upper_flags) & glb_en;
   end

   ips_prio_enc u_enc (
      .e (enc.enc)
   );

   // Presented request and vector. The cycle after an acknowledge is
   // forced idle, so a flag that the acknowledge clears is never
   // presented a second time from stale state.
   logic      req_q;
   logic      req_d;
   ips_prio_t prio_d;
   ips_addr_t vec_q;
   ips_addr_t vec_d;
   logic      rst_pend_d;
   logic      sysrst_q;
   logic      sysrst_d;

   assign ack_p = irq_ack & req_q;

   always_comb begin
      req_d  = enc.valid & ~ack_p;
      prio_d = enc.idx;
      vec_d  = vec_of(enc.idx);
      rst_pend_d = rst_pend_q;
      if (ack_p && prio_q == `IPS_P_RESET) begin
         rst_pend_d = 1'b0;
      end
      sysrst_d = por_event | rst_pin_reset | wdt_key_violation
               | (wdt_overflow & ~wdt_interval_mode);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_q      <= 1'b0;
         prio_q     <= '0;
         vec_q      <= '0;
         rst_pend_q <= 1'b1;
         sysrst_q   <= 1'b0;
      end else begin
         req_q      <= req_d;
         prio_q     <= prio_d;
         vec_q      <= vec_d;
         rst_pend_q <= rst_pend_d;
         sysrst_q   <= sysrst_d;
      end
   end

   assign irq_req          = req_q;
   assign irq_vec_addr     = vec_q;
   assign cpu_wake         = req_q;
   assign system_reset_req = sysrst_q;

   // Module enables; bit 0 changes meaning with the serial mode.
   assign serial_rx_module_enable   = img[`IPS_B_RXE] & ~sync_mode;
   assign sync_serial_module_enable = img[`IPS_B_RXE] & sync_mode;
   assign serial_tx_module_enable   = img[`IPS_B_TXE] & ~sync_mode;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic ack_free;
   assign ack_free = !(irq_ack && irq_req);

   property p_reset_vec;
      rst_pend_q && ack_free |=> irq_req
         && irq_vec_addr == vec_of(`IPS_P_RESET);
   endproperty
   a_reset_vec:
      assert property (p_reset_vec) else $error("Reset vector missing.");

   property p_nmi_taken;
      img[`IPS_B_NMI] && !rst_pend_q && ack_free |=> irq_req
         && irq_vec_addr == vec_of(`IPS_P_NMI);
   endproperty
   a_nmi_taken:
      assert property (p_nmi_taken) else $error("Pin NMI not taken.");

   property p_of_masked;
      !img[`IPS_B_OF_EN] && !img[`IPS_B_NMI] |=>
         !(irq_req && irq_vec_addr == vec_of(`IPS_P_NMI));
   endproperty
   a_of_masked:
      assert property (p_of_masked) else $error("Masked fault taken.");

   property p_of_no_glb;
      img[`IPS_B_OF] && img[`IPS_B_OF_EN] && !glb_en && !rst_pend_q
         && ack_free |=> irq_req && irq_vec_addr == vec_of(`IPS_P_NMI);
   endproperty
   a_of_no_glb:
      assert property (p_of_no_glb) else $error("Fault blocked by enable.");

   property p_glb_gate;
      !glb_en |=> !irq_req || irq_vec_addr >= vec_of(`IPS_P_NMI);
   endproperty
   a_glb_gate:
      assert property (p_glb_gate) else $error("Maskable taken while off.");

   property p_highest;
      enc.valid |-> enc.req[enc.idx] && (enc.req >> enc.idx) == 16'h0001;
   endproperty
   a_highest:
      assert property (p_highest) else $error("Lower priority chosen.");

   property p_wdt_set;
      wdt_overflow || wdt_key_violation |=> img[`IPS_B_WDT];
   endproperty
   a_wdt_set:
      assert property (p_wdt_set) else $error("Watchdog flag not set.");

   property p_wdt_clr;
      $fell(sys_rst) && $past(por_event) |-> !img[`IPS_B_WDT];
   endproperty
   a_wdt_clr:
      assert property (p_wdt_clr) else $error("Watchdog flag kept.");

   property p_rst_vals;
      $fell(sys_rst) |-> img[`IPS_B_OF] && img[`IPS_B_TX]
         && !img[`IPS_B_RX] && img[15:0] == 16'h0000;
   endproperty
   a_rst_vals:
      assert property (p_rst_vals) else $error("Bad reset value.");

   property p_unmapped;
      sfr_rd && sfr_hit && sfr_ofs == `IPS_OFS_ME1 |=> sfr_rdata == '0;
   endproperty
   a_unmapped:
      assert property (p_unmapped) else $error("Reserved byte not zero.");

   property p_wake;
      img[`IPS_B_NMI] && ack_free |=> cpu_wake;
   endproperty
   a_wake:
      assert property (p_wake) else $error("No wake on NMI.");

   c_reset_ack: cover property (ack_p && prio_q == `IPS_P_RESET);
   c_nmi_req:   cover property (irq_req && prio_q == `IPS_P_NMI);
   c_port_low:  cover property (ack_p && prio_q == `IPS_P_P0U);
   c_two_pend:  cover property (enc.req[`IPS_P_P00] && enc.req[`IPS_P_P01]);
endmodule
`default_nettype wire

// ---- verification/ips_core_model.sv ----
`default_nettype none
module ips_core_model (
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               ack_en,
   input  wire logic               slow,
   input  wire logic               irq_req,
   input  wire ips_pkg::ips_addr_t irq_vec_addr,
   input  wire logic               cpu_wake,
   output var  logic               irq_ack,
   output var  ips_pkg::ips_addr_t last_vec,
   output var  int                 ack_count
);
   timeunit 1ns;
   timeprecision 1ps;
   import ips_pkg::*;
   int wait_q;
   // A slow core lets the request stand a few cycles before it answers.
   always @(posedge clk) begin
      if (sys_rst) begin
         irq_ack   <= 1'b0;
         wait_q    <= 0;
         ack_count <= 0;
         last_vec  <= 16'h0000;
      end else if (irq_ack) begin
         // The vector is taken at the same edge that samples the ack.
         // An ack that meets a dropped request is refused, so not counted.
         irq_ack   <= 1'b0;
         if (irq_req === 1'b1) begin
            last_vec  <= irq_vec_addr;
            ack_count <= ack_count + 1;
         end
      end else if (ack_en && irq_req === 1'b1
                   && cpu_wake === 1'b1) begin
         if (wait_q >= (slow ? 3 : 0)) begin
            irq_ack <= 1'b1;
            wait_q  <= 0;
         end else begin
            wait_q <= wait_q + 1;
         end
      end else begin
         wait_q <= 0;
      end
   end
endmodule
`default_nettype wire

// ---- verification/ips_sfr_irq_tb_top.sv ----
`default_nettype none
module ips_sfr_irq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ips_pkg::*;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1, por = 1'b1, pin_rst = 1'b0, nmi = 1'b0;
   logic       key_viol = 1'b0, wdt_ivl = 1'b1, osc = 1'b0, sync = 1'b0;
   logic       glb_en = 1'b0, rd = 1'b0, wr = 1'b0;
   logic       ack_en = 1'b1, slow = 1'b0;
   logic [5:0] pulse = 6'h00;
   logic [5:0] lv = 6'h00;
   ips_addr_t  addr = 16'h0000;
   ips_byte_t  wdata = 8'h00;
   ips_byte_t  rdata;
   ips_addr_t  vec, last_vec;
   logic       irq_req, irq_ack, wake, sys_req, rx_me, tx_me, spi_me;
   int         ack_count;
   int         errors = 0;
   int         cmp_count = 0;
   logic [15:0] lvec [6] = '{16'hffe0, 16'hffe4, 16'hffe6, 16'hffe8,
                             16'hfff0, 16'hfff2};
   logic [15:0] pvec [6] = '{16'hfffa, 16'hfff8, 16'hfff4, 16'hffee,
                             16'hffec, 16'hffe2};
   logic [7:0]  imp [6] = '{8'h0f, 8'h87, 8'h1f, 8'h83, 8'h00, 8'h03};

   always #4 clk = ~clk;

   ips_sfr_irq dut (
      .clk(clk), .sys_rst(sys_rst), .por_event(por),
      .rst_pin_reset(pin_rst), .nmi_pin(nmi), .wdt_overflow(pulse[2]),
      .wdt_key_violation(key_viol), .wdt_interval_mode(wdt_ivl),
      .osc_fault_det(osc), .port0_bit0_set(pulse[0]),
      .port0_bit1_set(pulse[1]), .serial_rx_set(pulse[3]),
      .serial_tx_set(pulse[4]), .basic_timer_set(pulse[5]),
      .port0_upper_flags({lv[0], 5'h00}), .port1_flags({7'h00, lv[1]}),
      .port2_flags({lv[2], 7'h00}), .timer_port_req(lv[3]),
      .timer_a_cc0_req(lv[5]), .timer_a_req(lv[4]), .sync_mode(sync),
      .global_irq_enable(glb_en), .sfr_addr(addr), .sfr_rd(rd),
      .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rdata(rdata),
      .irq_req(irq_req), .irq_vec_addr(vec), .irq_ack(irq_ack),
      .cpu_wake(wake), .system_reset_req(sys_req),
      .serial_rx_module_enable(rx_me), .serial_tx_module_enable(tx_me),
      .sync_serial_module_enable(spi_me)
   );

   ips_core_model core (
      .clk(clk), .sys_rst(sys_rst), .ack_en(ack_en), .slow(slow),
      .irq_req(irq_req), .irq_vec_addr(vec), .cpu_wake(wake),
      .irq_ack(irq_ack), .last_vec(last_vec), .ack_count(ack_count)
   );

   task automatic print_verdict();
      $display("errors %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic wait_ack(input logic [15:0] exp);
      int c0;
      int k;
      c0 = ack_count;
      for (k = 0; k < 40 && ack_count == c0; k++) cycles(1);
      check(16'(ack_count != c0), 16'h1);
      check(last_vec, exp);
   endtask

   // Counting acks rather than sampling the level avoids missing a request.
   task automatic no_req();
      int c0;
      c0 = ack_count;
      cycles(12);
      check(16'(ack_count - c0), 16'h0);
   endtask

   task automatic wait_rst();
      int k;
      // The request stands one cycle only, so look right after this edge.
      #1;
      for (k = 0; k < 6 && sys_req !== 1'b1; k++) cycles(1);
      check(16'(sys_req), 16'h0001);
   endtask

   task automatic do_reset(input logic p, input logic q);
      @(posedge clk);
      sys_rst <= 1'b1;
      por <= p;
      pin_rst <= q;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      por <= 1'b0;
      pin_rst <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end

   initial begin
      int i;
      do_reset(1'b1, 1'b0);
      wait_ack(16'hfffe);
      @(posedge clk) ack_en <= 1'b0;
      for (i = 0; i < 16; i++) begin
         rd_reg(16'(i), (i == 2 || i == 3) ? 8'h02 : 8'h00);
      end
      for (i = 0; i < 16; i++) begin
         wr_reg(16'(i), 8'hff);
         rd_reg(16'(i), (i < 6) ? imp[i] : 8'h00);
      end
      for (i = 0; i < 6; i++) begin
         wr_reg(16'(i), 8'h00);
         rd_reg(16'(i), 8'h00);
      end
      wr_reg(16'h0100, 8'hff);
      rd_reg(16'h0000, 8'h00);
      wr_reg(16'h0005, 8'h03);
      cycles(2);
      check(rx_me, 1'b1);
      check(tx_me, 1'b1);
      check(spi_me, 1'b0);
      @(posedge clk) sync <= 1'b1;
      cycles(2);
      check(spi_me, 1'b1);
      check(tx_me, 1'b0);
      @(posedge clk) sync <= 1'b0;
      wr_reg(16'h0001, 8'h87);
      wr_reg(16'h0000, 8'h0d);
      @(posedge clk) lv <= 6'h3f;
      cycles(3);
      check(irq_req, 1'b0);
      @(posedge clk) glb_en <= 1'b1;
      for (i = 5; i >= 0; i--) begin
         cycles(3);
         check(irq_req, 1'b1);
         check(vec, lvec[i]);
         @(posedge clk) lv[i] <= 1'b0;
      end
      cycles(3);
      check(irq_req, 1'b0);
      @(posedge clk) ack_en <= 1'b1;
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         pulse[i] <= 1'b1;
         slow <= i[0];
         @(posedge clk);
         pulse <= 6'h00;
         wait_ack(pvec[i]);
      end
      rd_reg(16'h0002, 8'h00);
      rd_reg(16'h0003, 8'h00);
      @(posedge clk);
      glb_en <= 1'b0;
      pulse[0] <= 1'b1;
      @(posedge clk);
      pulse <= 6'h00;
      no_req();
      rd_reg(16'h0002, 8'h04);
      @(posedge clk) glb_en <= 1'b1;
      wait_ack(16'hfffa);
      wr_reg(16'h0000, 8'h00);
      @(posedge clk);
      glb_en <= 1'b0;
      nmi <= 1'b1;
      wait_ack(16'hfffc);
      rd_reg(16'h0002, 8'h10);
      wr_reg(16'h0002, 8'h00);
      @(posedge clk) nmi <= 1'b0;
      cycles(6);
      @(posedge clk);
      glb_en <= 1'b1;
      osc <= 1'b1;
      @(posedge clk);
      osc <= 1'b0;
      no_req();
      rd_reg(16'h0002, 8'h02);
      @(posedge clk) glb_en <= 1'b0;
      wr_reg(16'h0000, 8'h02);
      wait_ack(16'hfffc);
      wr_reg(16'h0000, 8'h00);
      @(posedge clk);
      wdt_ivl <= 1'b0;
      pulse[2] <= 1'b1;
      @(posedge clk);
      pulse <= 6'h00;
      wait_rst();
      do_reset(1'b0, 1'b0);
      wait_ack(16'hfffe);
      rd_reg(16'h0002, 8'h03);
      @(posedge clk) key_viol <= 1'b1;
      @(posedge clk) key_viol <= 1'b0;
      wait_rst();
      do_reset(1'b0, 1'b1);
      wait_ack(16'hfffe);
      rd_reg(16'h0002, 8'h02);
      print_verdict();
   end
endmodule
`default_nettype wire
